//--- rtl/bridge_ctl_pkg.sv
// Constants for the bridge general control and secondary clock control block
package bridge_ctl_pkg;
  localparam logic [7:0]  gen_ctl_offset      = 8'hd4;
  localparam logic [7:0]  clk_ctl_offset      = 8'hd8;
  localparam logic [7:0]  clk_mask_offset     = 8'hd9;
  localparam logic [31:0] gen_ctl_reset       = 32'h0006_c000;
  localparam logic [31:0] gen_ctl_rw_mask     = 32'h007f_ffff;
  localparam logic [7:0]  clk_ctl_reset       = 8'h00;
  localparam logic [7:0]  clk_rw_mask         = 8'h7f;
  localparam int          prefetch_off_bit    = 19;
  localparam int          shallow_lat_lsb     = 16;
  localparam int          deep_lat_lsb        = 13;
  localparam int          vc_cap_bit          = 12;
  localparam int          d3_stop_bit         = 11;
  localparam int          beacon_bit          = 10;
  localparam int          power_scale_lsb     = 8;
  localparam int          power_value_lsb     = 0;
  localparam int          override_lsb        = 20;
  localparam logic [2:0]  override_clk_off    = 3'h2;
  localparam logic [2:0]  override_clk_off_pw = 3'h3;
  localparam logic [11:0] aer_next_off        = 12'h000;
  localparam logic [11:0] aer_next_vc         = 12'h150;
  localparam logic [1:0]  pm_state_d3         = 2'h3;
endpackage

//--- rtl/bridge_general_and_clock_control.sv
// Bridge general control low bits and secondary clock output gating
// How it works
// [RULE_01] Prefetch-off bit clear prefetches to cache line; set fetches one dword.
// [RULE_02] Shallow idle exit latency bits 18:16 mirror into capability bits 8:6.
// [RULE_03] Deep idle exit latency bits 15:13 mirror into capability bits 11:9.
// [RULE_04] VC enable makes error header next offset 150h, else 000h.
// [RULE_05] D3 clock-stop enable stops all secondary clocks while in D3.
// [RULE_06] Beacon-select clear wakes by wake only; set uses beacon and wake.
// [RULE_07] Power scale bits 9:8 select multiplier 1.0, 0.1, 0.01, 0.001.
// [RULE_08] Eight-bit minimum power value, reset 00h, reprogrammed by firmware.
// [RULE_09] Resettable fields return to default on link, global or power-on reset.
// [RULE_10] D3 stop and beacon bits survive link and global reset.
// [RULE_11] Clock control bits 6:0 disable outputs 0 to 6, reset 00h.
// [RULE_12] Clock control bit 7 reads zero and ignores writes.
// [RULE_13] Override clock-off code plus exceeded power limit stops masked clocks.
// [RULE_14] Stopped clocks are gated glitch-free and held low.
`timescale 1ns/1ns
module bridge_general_and_clock_control #(
  parameter int num_clocks = 7
) (
  // Clock and resets
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic                  link_reset,
  input  wire logic                  global_reset_input,
  // Configuration access
  input  wire logic [7:0]            cfg_addr,
  input  wire logic                  cfg_wr,
  input  wire logic [3:0]            cfg_be,
  input  wire logic [31:0]           cfg_wdata,
  input  wire logic                  cfg_rd,
  output logic [31:0]                cfg_rdata,
  // Power state and slot power
  input  wire logic [1:0]            pm_state,
  input  wire logic                  slot_power_exceeded,
  input  wire logic                  l2_wake_request,
  // Policy outputs
  output logic                       burst_prefetch_off,
  output logic                       single_dword_fetch,
  output logic [2:0]                 cap_shallow_idle_latency,
  output logic [2:0]                 cap_deep_idle_latency,
  output logic [11:0]                aer_next_cap_offset,
  output logic [1:0]                 min_power_scale,
  output logic [7:0]                 min_power_value,
  output logic                       wake_out,
  output logic                       beacon_out,
  // Secondary clocks
  input  wire logic                  sec_clk_src,
  output logic [num_clocks-1:0]      secondary_clock_output
);
  // Only seven disable bits exist in the clock control byte
  if (num_clocks < 1 || num_clocks > 7) begin : g_bad_num_clocks
    $error("num_clocks must be 1 to 7");
  end

  logic [31:0]           gen_ff;
  logic [31:0]           nxt_gen;
  logic [7:0]            clk_ctl_ff;
  logic [7:0]            nxt_clk_ctl;
  logic [7:0]            clk_mask_ff;
  logic [7:0]            nxt_clk_mask;
  logic [1:0]            pm_sync_ff;
  logic [1:0]            pm_ff;
  logic [1:0]            lim_sync_ff;
  logic [1:0]            wake_sync_ff;
  logic [1:0]            src_sync_ff;
  logic [num_clocks-1:0] run_ff;
  logic [num_clocks-1:0] clk_out_ff;
  logic [31:0]           rdata_ff;

  wire logic [31:0] be_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}},
                               {8{cfg_be[1]}}, {8{cfg_be[0]}}};
  wire logic gen_hit  = cfg_addr == bridge_ctl_pkg::gen_ctl_offset;
  wire logic clk_hit  = cfg_addr == bridge_ctl_pkg::clk_ctl_offset;
  wire logic mask_hit = cfg_addr == bridge_ctl_pkg::clk_mask_offset;
  wire logic [31:0] gen_wmask = be_mask & bridge_ctl_pkg::gen_ctl_rw_mask;
  wire logic full_reset = srst | link_reset | global_reset_input; // RULE_09
  wire logic [1:0] sticky_mask_pos = 2'h3;
  wire logic [31:0] sticky_bits =
    32'(sticky_mask_pos) << bridge_ctl_pkg::beacon_bit;

  // Sticky bits clear only on power-on reset or a write, never on link or global reset
  always_comb begin
    nxt_gen = gen_ff;
    if (cfg_wr && gen_hit) begin
      nxt_gen = (gen_ff & ~gen_wmask) | (cfg_wdata & gen_wmask);
    end
    if (srst) begin
      nxt_gen = bridge_ctl_pkg::gen_ctl_reset; // RULE_09
    end else if (link_reset || global_reset_input) begin
      nxt_gen = (bridge_ctl_pkg::gen_ctl_reset & ~sticky_bits)
                | (gen_ff & sticky_bits); // RULE_10
    end
  end

  // Clock control and mask: byte lane 0 only, bit 7 fixed low
  assign nxt_clk_ctl = full_reset ? bridge_ctl_pkg::clk_ctl_reset :
    (cfg_wr && clk_hit && cfg_be[0]) ?
      (cfg_wdata[7:0] & bridge_ctl_pkg::clk_rw_mask) : clk_ctl_ff; // RULE_12
  assign nxt_clk_mask = full_reset ? bridge_ctl_pkg::clk_ctl_reset :
    (cfg_wr && mask_hit && cfg_be[0]) ?
      (cfg_wdata[7:0] & bridge_ctl_pkg::clk_rw_mask) : clk_mask_ff;

  always_ff @(posedge clk) begin
    gen_ff      <= nxt_gen;
    clk_ctl_ff  <= nxt_clk_ctl; // RULE_11
    clk_mask_ff <= nxt_clk_mask;
  end

  // Field decode
  wire logic [2:0] ovr =
    gen_ff[bridge_ctl_pkg::override_lsb +: 3];
  wire logic in_d3 = pm_ff == bridge_ctl_pkg::pm_state_d3;
  wire logic d3_stop = gen_ff[bridge_ctl_pkg::d3_stop_bit] && in_d3; // RULE_05
  wire logic ovr_stop = (ovr == bridge_ctl_pkg::override_clk_off ||
                         ovr == bridge_ctl_pkg::override_clk_off_pw)
                        && lim_sync_ff[1]; // RULE_13
  wire logic [num_clocks-1:0] want_run =
    ~(clk_ctl_ff[num_clocks-1:0]
      | (ovr_stop ? clk_mask_ff[num_clocks-1:0] : '0)
      | {num_clocks{d3_stop}}); // RULE_11
  wire logic [31:0] rd_mux =
    gen_hit  ? gen_ff :
    clk_hit  ? {24'h0, clk_ctl_ff} :
    mask_hit ? {24'h0, clk_mask_ff} : 32'h0; // RULE_12

  // Pin inputs are synchronised before use
  always_ff @(posedge clk) begin
    if (srst) begin
      pm_sync_ff   <= 2'h0;
      pm_ff        <= 2'h0;
      lim_sync_ff  <= 2'h0;
      wake_sync_ff <= 2'h0;
      rdata_ff     <= 32'h0;
    end else begin
      pm_sync_ff   <= pm_state;
      pm_ff        <= pm_sync_ff;
      lim_sync_ff  <= {lim_sync_ff[0], slot_power_exceeded};
      wake_sync_ff <= {wake_sync_ff[0], l2_wake_request};
      rdata_ff     <= cfg_rd ? rd_mux : rdata_ff;
    end
  end

  // Field slices of the general control word
  wire logic        fld_prefetch_off =
    gen_ff[bridge_ctl_pkg::prefetch_off_bit];
  wire logic [2:0]  fld_shallow_lat =
    gen_ff[bridge_ctl_pkg::shallow_lat_lsb +: 3];
  wire logic [2:0]  fld_deep_lat =
    gen_ff[bridge_ctl_pkg::deep_lat_lsb +: 3];
  wire logic        fld_vc_on =
    gen_ff[bridge_ctl_pkg::vc_cap_bit];
  wire logic        fld_beacon_on =
    gen_ff[bridge_ctl_pkg::beacon_bit];
  wire logic [1:0]  fld_power_scale =
    gen_ff[bridge_ctl_pkg::power_scale_lsb +: 2];
  wire logic [7:0]  fld_power_value =
    gen_ff[bridge_ctl_pkg::power_value_lsb +: 8];
  wire logic [11:0] sel_aer_offset = fld_vc_on ?
    bridge_ctl_pkg::aer_next_vc : bridge_ctl_pkg::aer_next_off; // RULE_04

  // Latency reset values follow the control word default
  wire logic [2:0]  rst_shallow_lat =
    bridge_ctl_pkg::gen_ctl_reset[bridge_ctl_pkg::shallow_lat_lsb +: 3];
  wire logic [2:0]  rst_deep_lat =
    bridge_ctl_pkg::gen_ctl_reset[bridge_ctl_pkg::deep_lat_lsb +: 3];

  // Registered policy outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      burst_prefetch_off       <= 1'b0;
      single_dword_fetch       <= 1'b0;
      cap_shallow_idle_latency <= rst_shallow_lat;
      cap_deep_idle_latency    <= rst_deep_lat;
      aer_next_cap_offset      <= bridge_ctl_pkg::aer_next_off;
      min_power_scale          <= 2'h0;
      min_power_value          <= 8'h00;
      wake_out                 <= 1'b0;
      beacon_out               <= 1'b0;
    end else begin
      burst_prefetch_off       <= fld_prefetch_off; // RULE_01
      single_dword_fetch       <= fld_prefetch_off; // RULE_01
      cap_shallow_idle_latency <= fld_shallow_lat; // RULE_02
      cap_deep_idle_latency    <= fld_deep_lat; // RULE_03
      aer_next_cap_offset      <= sel_aer_offset; // RULE_04
      min_power_scale          <= fld_power_scale; // RULE_07
      min_power_value          <= fld_power_value; // RULE_08
      wake_out                 <= wake_sync_ff[1]; // RULE_06
      beacon_out               <= wake_sync_ff[1] && fld_beacon_on; // RULE_06
    end
  end

  assign cfg_rdata = rdata_ff;

  // The source is a pin, so it is resampled on clk through two flops.
  // Limitation: the source must toggle no faster than half of clk.
  // Enables change only in the low phase, so no shortened pulse escapes
  wire logic                  src_low     = !src_sync_ff[1];
  wire logic [num_clocks-1:0] nxt_run     = src_low ? want_run : run_ff;
  wire logic [num_clocks-1:0] nxt_clk_out =
    {num_clocks{src_sync_ff[1]}} & run_ff;

  // Every output edge comes from one flop, so a stop holds it low cleanly
  always_ff @(posedge clk) begin
    if (srst) begin
      src_sync_ff <= 2'h0;
      run_ff      <= '0;
      clk_out_ff  <= '0;
    end else begin
      src_sync_ff <= {src_sync_ff[0], sec_clk_src};
      run_ff      <= nxt_run; // RULE_14
      clk_out_ff  <= nxt_clk_out; // RULE_14
    end
  end

  assign secondary_clock_output = clk_out_ff;
endmodule // bridge_general_and_clock_control

//--- tb/bridge_ctl_asserts.sv
// Checker for the general control and secondary clock control block
`timescale 1ns/1ns
module bridge_ctl_asserts #(parameter int num_clocks = 7) (
  input wire logic clk, srst, link_reset, global_reset_input, cfg_wr, cfg_rd,
  input wire logic [7:0] cfg_addr, min_power_value,
  input wire logic [31:0] cfg_rdata,
  input wire logic [1:0] pm_state, min_power_scale,
  input wire logic wake_out, beacon_out, burst_prefetch_off, single_dword_fetch,
  input wire logic [2:0] cap_shallow_idle_latency, cap_deep_idle_latency,
  input wire logic [11:0] aer_next_cap_offset,
  input wire logic [num_clocks-1:0] secondary_clock_output
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Read data and outputs both lag the register by one cycle when no write
  wire quiet  = !cfg_wr && !link_reset && !global_reset_input;
  wire rd_gen = cfg_rd && cfg_addr == 8'hd4 && quiet;
  a_latency_mirror: assert property (
    rd_gen |=> cap_shallow_idle_latency == cfg_rdata[18:16] &&
    cap_deep_idle_latency == cfg_rdata[15:13]) else $error("latency copy");
  a_power_fields: assert property (
    rd_gen |=> min_power_scale == cfg_rdata[9:8] && burst_prefetch_off ==
    cfg_rdata[19] && single_dword_fetch == cfg_rdata[19] &&
    min_power_value == cfg_rdata[7:0]) else $error("power or fetch field");
  a_vc_offset: assert property (
    rd_gen |=> aer_next_cap_offset == (cfg_rdata[12] ? 12'h150 : 12'h000))
    else $error("next offset");
  a_beacon_gate: assert property (
    rd_gen |=> beacon_out == (wake_out && cfg_rdata[10])) else $error("beacon");
  a_d3_stop: assert property (
    rd_gen ##1 (cfg_rdata[11] && pm_state == 2'h3 && quiet && !cfg_rd)[*8]
    |-> secondary_clock_output == '0) else $error("clocks run in D3");
  a_off_low: assert property (
    (cfg_rd && cfg_addr == 8'hd8 && quiet) ##1 (quiet && !cfg_rd)[*6] |->
    (secondary_clock_output & cfg_rdata[num_clocks-1:0]) == '0)
    else $error("disabled clock not low");
  a_reserved_bit7: assert property (
    cfg_rd && cfg_addr == 8'hd8 |=> cfg_rdata[31:7] == '0) else $error("bit7");
  a_link_default: assert property (
    $fell(link_reset) || $fell(global_reset_input) |->
    cap_shallow_idle_latency == 3'h6 && cap_deep_idle_latency == 3'h6 &&
    aer_next_cap_offset == 12'h000 && min_power_value == 8'h00 &&
    min_power_scale == 2'h0 && !burst_prefetch_off) else $error("defaults");
endmodule // bridge_ctl_asserts
bind bridge_general_and_clock_control bridge_ctl_asserts
  #(.num_clocks(num_clocks)) i_bridge_ctl_asserts (.*);

//--- tb/sec_bus_devices.sv
// Secondary bus devices that count rising edges of each clock output
`timescale 1ns/1ns
module sec_bus_devices #(parameter int n = 7) (
  input  wire logic [n-1:0] sec_clk,
  output int unsigned       edges [n]
);
  for (genvar i = 0; i < n; i++) begin : g_dev
    initial edges[i] = 0;
    always @(posedge sec_clk[i]) edges[i] <= edges[i] + 1;
  end
endmodule // sec_bus_devices

//--- tb/tb_top.sv
// Self-checking bench for the general and clock control block
`timescale 1ns/1ns
module tb_top;
  `define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("Error %0t: value mismatch", $time); end end
  logic clk = 0, srst = 1, link_reset = 0, global_reset_input = 0;
  logic cfg_wr = 0, cfg_rd = 0, slot_power_exceeded = 0;
  logic l2_wake_request = 0, sec_clk_src = 0;
  logic [7:0] cfg_addr = 8'h00, min_power_value;
  logic [3:0] cfg_be = 4'hf;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata, gen, d, v, b, seed = 32'h3a39;
  logic [1:0] pm_state = 2'h0, min_power_scale;
  logic burst_prefetch_off, single_dword_fetch, wake_out, beacon_out;
  logic [2:0] cap_shallow_idle_latency, cap_deep_idle_latency;
  logic [11:0] aer_next_cap_offset;
  logic [6:0] secondary_clock_output;
  int unsigned edges [7], e0 [7];
  int bad_count = 0, total_checks = 0, cyc = 0;
  bridge_general_and_clock_control i_bridge_general_and_clock_control (.*);
  sec_bus_devices i_sec_bus_devices (.sec_clk(secondary_clock_output),
    .edges(edges));
  function logic [31:0] xs();
    seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
    return seed;
  endfunction
  task close_out();
    if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always #25 clk = ~clk;
  always @(posedge clk) begin
    sec_clk_src <= ~sec_clk_src;
    cyc++;
    if (cyc == 20000) begin bad_count++; close_out(); end
  end
  task wr(input logic [7:0] a, input logic [31:0] w,
          input logic [3:0] be = 4'hf);
    @(posedge clk); cfg_wr <= 1; cfg_addr <= a; cfg_wdata <= w;
    cfg_be <= be;
    @(posedge clk); cfg_wr <= 0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk); cfg_rd <= 1; cfg_addr <= a;
    @(posedge clk); cfg_rd <= 0;
    @(posedge clk); #1 d = cfg_rdata;
  endtask
  // Edges seen by the devices over a window show which clocks are stopped
  task clocks(input logic [6:0] off);
    repeat (12) @(posedge clk);
    e0 = edges;
    repeat (20) @(posedge clk);
    for (int i = 0; i < 7; i++) `CHK(edges[i] == e0[i], off[i])
  endtask
  initial begin
    repeat (8) @(posedge clk); srst <= 0;
    rd(8'hd4); `CHK(d, 32'h0006_c000)
    gen = 32'h0006_c000;
    repeat (6) begin
      v = xs(); b = xs(); l2_wake_request <= v[31]; wr(8'hd4, v, b[3:0]);
      for (int j = 0; j < 4; j++) if (b[j]) gen[8*j +: 8] = v[8*j +: 8];
      gen &= 32'h007f_ffff; rd(8'hd4); `CHK(d, gen)
      `CHK({burst_prefetch_off, single_dword_fetch, cap_shallow_idle_latency, cap_deep_idle_latency}, {gen[19], gen[19], gen[18:13]})
      `CHK({aer_next_cap_offset, min_power_scale, min_power_value}, {gen[12] ? 12'h150 : 12'h000, gen[9:0]})
      `CHK({wake_out, beacon_out}, {v[31], v[31] & gen[10]})
    end
    repeat (3) begin
      v = xs(); wr(8'hd8, v); rd(8'hd8); `CHK(d, v & 32'h7f)
      clocks(v[6:0]);
    end
    pm_state <= 2'h3; gen |= 32'h800; wr(8'hd4, gen); rd(8'hd4);
    clocks(7'h7f);
    pm_state <= 2'h0;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk); link_reset <= k == 0; global_reset_input <= k == 1;
      repeat (2) @(posedge clk); link_reset <= 0; global_reset_input <= 0;
      gen = (gen & 32'hc00) | 32'h0006_c000;
      rd(8'hd4); `CHK(d, gen)
      rd(8'hd8); `CHK(d, 32'h0)
    end
    clocks(7'h00);
    wr(8'hd9, 32'h5); wr(8'hd4, 32'h0020_0000); slot_power_exceeded <= 1;
    clocks(7'h05);
    slot_power_exceeded <= 0;
    clocks(7'h00);
    close_out();
  end
endmodule // tb_top
